// [rtl/iois_params.svh]
`ifndef IOIS_PARAMS_SVH
`define IOIS_PARAMS_SVH

// ************************************************************
// Register map, byte addresses on the AXI4-Lite slave
// ************************************************************
`define IOIS_ADDR_W            8
`define IOIS_OFF_MASK          8'h00
`define IOIS_OFF_SEL           8'h04
`define IOIS_OFF_LVL           8'h08
`define IOIS_OFF_STO           8'h0C
`define IOIS_OFF_STAT          8'h10
`define IOIS_OFF_LINES         8'h14
`define IOIS_OFF_CTRL          8'h18

// ************************************************************
// Reset values
// ************************************************************
`define IOIS_RST_MASK          32'h0000_0000
`define IOIS_RST_SEL           32'h0000_0000
`define IOIS_RST_LVL           32'h0000_0000
`define IOIS_RST_STO           32'h0000_0000

// ************************************************************
// Field positions
// ************************************************************
`define IOIS_LINE_MASK         32'h0000_03FF
`define IOIS_OUT_INV0_BIT      0
`define IOIS_OUT_INV1_BIT      1
`define IOIS_STAT_REFUSED_BIT  0
`define IOIS_STAT_SIMACT_BIT   1
`define IOIS_CTRL_SAVE_BIT     0
`define IOIS_CTRL_RESTORE_BIT  1

// ************************************************************
// Bus responses
// ************************************************************
`define IOIS_RESP_OKAY         2'h0
`define IOIS_RESP_SLVERR       2'h2

`endif

// [rtl/iois_pkg.sv]
package iois_pkg;

  typedef logic [31:0] iois_word_t;
  typedef logic [9:0]  iois_lines_t;
  typedef logic [1:0]  iois_outs_t;
  typedef logic [1:0]  iois_resp_t;

  typedef enum logic [2:0] {
    iois_reg_mask,
    iois_reg_sel,
    iois_reg_lvl,
    iois_reg_sto,
    iois_reg_stat,
    iois_reg_lines,
    iois_reg_ctrl,
    iois_reg_none
  } iois_reg_e;

endpackage : iois_pkg

// [rtl/iois_input_cond.sv]
`timescale 1ns/1ps
module iois_input_cond
  import iois_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire iois_lines_t terminal_level,
  input  wire iois_lines_t sim_select,
  input  wire iois_lines_t sim_level,
  input  wire iois_lines_t sto_source,
  output logic [9:0]       input_line
);

  // ************************************************************
  // Per-line source selection
  // ************************************************************
  // Safe torque off lines are forced to terminal here as well, so a
  // stale select bit can never reach the safety path
  for (genvar i = 0; i < 10; i++) begin : g_line
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        input_line[i] <= 1'b0;
      end else if (sim_select[i] && !sto_source[i]) begin // [RQ3] [RQ5]
        input_line[i] <= sim_level[i]; // [RQ4]
      end else begin
        input_line[i] <= terminal_level[i]; // [RQ3]
      end
    end

    property p_terminal_path;
      @(posedge aclk) disable iff (!aresetn)
      (!sim_select[i] || sto_source[i]) |=> input_line[i] == $past(terminal_level[i]);
    endproperty
    a_terminal_path: assert property (p_terminal_path) // [RQ3]
      else $error("input line not on terminal level");

    property p_sim_path;
      @(posedge aclk) disable iff (!aresetn)
      (sim_select[i] && !sto_source[i]) |=> input_line[i] == $past(sim_level[i]);
    endproperty
    a_sim_path: assert property (p_sim_path) // [RQ4]
      else $error("simulated input line wrong level");
  end

endmodule : iois_input_cond

// [rtl/iois_top.sv]
// Contract
// [RQ1] Mask bit 0 inverts output line one
// [RQ2] Mask bit 1 inverts output line two
// [RQ3] Select bits 0-9 pick terminal or simulation
// [RQ4] Simulated line shows matching level register bit
// [RQ5] Simulation refused on safe torque off lines
// [RQ6] Simulation registers excluded from save and restore; a restore still clears select bits 0-9 on the restored safety source lines
// [RQ7] Writes act at once in any drive state
// [RQ8] Upper bits stored but drive nothing
`timescale 1ns/1ps
`include "iois_params.svh"
module iois_top
  import iois_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [`IOIS_ADDR_W-1:0] awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [`IOIS_ADDR_W-1:0] araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  input  wire iois_lines_t             terminal_level,
  input  wire iois_outs_t              internal_out,
  output wire iois_lines_t             input_line,
  output logic [1:0]                   output_line
);

  // ************************************************************
  // Decoding and byte-lane helpers
  // ************************************************************
  function automatic iois_reg_e decode_addr(input logic [`IOIS_ADDR_W-1:0] a);
    if (a == `IOIS_OFF_MASK) begin
      return iois_reg_mask;
    end else if (a == `IOIS_OFF_SEL) begin
      return iois_reg_sel;
    end else if (a == `IOIS_OFF_LVL) begin
      return iois_reg_lvl;
    end else if (a == `IOIS_OFF_STO) begin
      return iois_reg_sto;
    end else if (a == `IOIS_OFF_STAT) begin
      return iois_reg_stat;
    end else if (a == `IOIS_OFF_LINES) begin
      return iois_reg_lines;
    end else if (a == `IOIS_OFF_CTRL) begin
      return iois_reg_ctrl;
    end else begin
      return iois_reg_none;
    end
  endfunction : decode_addr

  function automatic iois_word_t merge_strb(input iois_word_t old_v, input iois_word_t new_v,
                                            input logic [3:0] strb);
    iois_word_t res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  // ************************************************************
  // Storage
  // ************************************************************
  iois_word_t  output_polarity_mask;
  iois_word_t  input_simulation_select;
  iois_word_t  input_simulation_level;
  iois_word_t  safe_torque_off_source;
  iois_word_t  saved_mask;
  iois_word_t  saved_sto;
  logic        refused;
  logic [`IOIS_ADDR_W-1:0] wr_addr;
  iois_word_t  wr_data;
  logic [3:0]  wr_strb;
  logic        wr_fire;
  iois_reg_e   wr_idx;
  iois_reg_e   rd_idx;
  iois_word_t  new_mask;
  iois_word_t  new_sel;
  iois_word_t  new_lvl;
  iois_word_t  new_sto;
  iois_word_t  sto_guard;
  logic        save_fire;
  logic        restore_fire;
  logic        sel_refused;

  // Both halves of a write are parked; commit waits for both and an idle response channel
  assign wr_fire      = !awready && !wready && !bvalid;
  assign wr_idx       = decode_addr(wr_addr);
  assign rd_idx       = decode_addr(araddr);
  assign new_mask     = merge_strb(output_polarity_mask, wr_data, wr_strb);
  assign new_sel      = merge_strb(input_simulation_select, wr_data, wr_strb);
  assign new_lvl      = merge_strb(input_simulation_level, wr_data, wr_strb);
  assign new_sto      = merge_strb(safe_torque_off_source, wr_data, wr_strb);
  assign sto_guard    = safe_torque_off_source & `IOIS_LINE_MASK;
  assign save_fire    = wr_fire && wr_idx == iois_reg_ctrl && wr_strb[0] && wr_data[`IOIS_CTRL_SAVE_BIT];
  assign restore_fire = wr_fire && wr_idx == iois_reg_ctrl && wr_strb[0] && wr_data[`IOIS_CTRL_RESTORE_BIT];
  assign sel_refused  = wr_fire && wr_idx == iois_reg_sel && |(new_sel & sto_guard);

  // ************************************************************
  // AXI4-Lite write channels
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wr_addr <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      wr_addr <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready  <= 1'b1;
      wr_data <= '0;
      wr_strb <= 4'h0;
    end else if (wvalid && wready) begin
      wready  <= 1'b0;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (bvalid && bready) begin
      wready  <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `IOIS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= (wr_idx == iois_reg_none) ? `IOIS_RESP_SLVERR : `IOIS_RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Registers written by software
  // ************************************************************
  // No drive-state qualifier anywhere: run or ready, a write lands at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_polarity_mask <= `IOIS_RST_MASK;
    end else if (wr_fire && wr_idx == iois_reg_mask) begin // [RQ7]
      output_polarity_mask <= new_mask; // [RQ8]
    end else if (restore_fire) begin
      output_polarity_mask <= saved_mask;
    end
  end

  // Refused bits are dropped on write and whenever a line becomes a safety source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_simulation_select <= `IOIS_RST_SEL;
    end else if (wr_fire && wr_idx == iois_reg_sel) begin // [RQ7]
      input_simulation_select <= new_sel & ~sto_guard; // [RQ5] [RQ8]
    end else if (wr_fire && wr_idx == iois_reg_sto) begin
      input_simulation_select <= input_simulation_select & ~(new_sto & `IOIS_LINE_MASK); // [RQ5]
    end else if (restore_fire) begin
      input_simulation_select <= input_simulation_select & ~(saved_sto & `IOIS_LINE_MASK); // [RQ5]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_simulation_level <= `IOIS_RST_LVL;
    end else if (wr_fire && wr_idx == iois_reg_lvl) begin // [RQ7]
      input_simulation_level <= new_lvl; // [RQ8]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      safe_torque_off_source <= `IOIS_RST_STO;
    end else if (wr_fire && wr_idx == iois_reg_sto) begin
      safe_torque_off_source <= new_sto;
    end else if (restore_fire) begin
      safe_torque_off_source <= saved_sto;
    end
  end

  // Backup image holds polarity and safety source only, never the simulation pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      saved_mask <= `IOIS_RST_MASK;
      saved_sto  <= `IOIS_RST_STO;
    end else if (save_fire) begin // [RQ6]
      saved_mask <= output_polarity_mask;
      saved_sto  <= safe_torque_off_source;
    end
  end

  // Sticky refusal flag; a new refusal beats a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refused <= 1'b0;
    end else if (sel_refused) begin // [RQ5]
      refused <= 1'b1;
    end else if (wr_fire && wr_idx == iois_reg_stat && wr_strb[0] && wr_data[`IOIS_STAT_REFUSED_BIT]) begin
      refused <= 1'b0;
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= `IOIS_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= `IOIS_RESP_OKAY;
      rdata   <= '0;
      case (rd_idx)
        iois_reg_mask:  rdata <= output_polarity_mask;
        iois_reg_sel:   rdata <= input_simulation_select;
        iois_reg_lvl:   rdata <= input_simulation_level;
        iois_reg_sto:   rdata <= safe_torque_off_source;
        iois_reg_stat:  rdata <= {30'h0000_0000, |(input_simulation_select & `IOIS_LINE_MASK), refused};
        iois_reg_lines: rdata <= {22'h00_0000, input_line};
        iois_reg_ctrl:  rdata <= '0;
        default:        rresp <= `IOIS_RESP_SLVERR;
      endcase
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  // ************************************************************
  // Line conditioning
  // ************************************************************
  // Outputs are registered, so an inversion shows one clock after the mask changes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_line <= 2'h0;
    end else begin
      output_line[0] <= internal_out[0] ^ output_polarity_mask[`IOIS_OUT_INV0_BIT]; // [RQ1]
      output_line[1] <= internal_out[1] ^ output_polarity_mask[`IOIS_OUT_INV1_BIT]; // [RQ2]
    end
  end

  iois_input_cond u_input_cond (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .terminal_level (terminal_level),
    .sim_select     (input_simulation_select[9:0]),
    .sim_level      (input_simulation_level[9:0]),
    .sto_source     (safe_torque_off_source[9:0]),
    .input_line     (input_line)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_out_inv0;
    1'b1 |=> output_line[0] == ($past(internal_out[0]) ^ $past(output_polarity_mask[0]));
  endproperty
  a_out_inv0: assert property (p_out_inv0) // [RQ1]
    else $error("output line one polarity wrong");

  property p_out_inv1;
    output_polarity_mask[1] |=> output_line[1] != $past(internal_out[1]);
  endproperty
  a_out_inv1: assert property (p_out_inv1) // [RQ2]
    else $error("output line two not inverted");

  property p_sto_excl;
    (input_simulation_select[9:0] & safe_torque_off_source[9:0]) == 10'h000;
  endproperty
  a_sto_excl: assert property (p_sto_excl) // [RQ5]
    else $error("simulation selected on safety source line");

  property p_refused_flag;
    sel_refused |=> refused;
  endproperty
  a_refused_flag: assert property (p_refused_flag) // [RQ5]
    else $error("refusal not flagged");

  property p_restore_keeps_sim;
    restore_fire |=> $stable(input_simulation_level) && output_polarity_mask == $past(saved_mask);
  endproperty
  a_restore_keeps_sim: assert property (p_restore_keeps_sim) // [RQ6]
    else $error("restore touched simulation level or missed mask");

  property p_mask_effect;
    (wr_fire && wr_idx == iois_reg_mask) |-> ##2 output_line == ($past(internal_out) ^ $past(new_mask[1:0], 2));
  endproperty
  a_mask_effect: assert property (p_mask_effect) // [RQ7]
    else $error("polarity write did not take effect in two cycles");

  property p_upper_kept;
    (wr_fire && wr_idx == iois_reg_lvl) |=> input_simulation_level[31:10] == $past(new_lvl[31:10]);
  endproperty
  a_upper_kept: assert property (p_upper_kept) // [RQ8]
    else $error("upper level bits not stored");

  property p_b_hold;
    (bvalid && !bready) |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");

  property p_unmapped_read;
    (arvalid && arready && rd_idx == iois_reg_none) |=> rvalid && rresp == `IOIS_RESP_SLVERR;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not answered with error");

  c_mask_write:  cover property (wr_fire && wr_idx == iois_reg_mask);
  c_refused:     cover property (sel_refused);
  c_restore:     cover property (restore_fire);
  c_read_error:  cover property (arvalid && arready && rd_idx == iois_reg_none);

endmodule : iois_top

// [testbench/iois_field_model.sv]
`timescale 1ns/1ps
module iois_field_model
  import iois_pkg::*;
(
  input  wire logic        aclk,
  input  wire iois_lines_t sensor_drive,
  output iois_lines_t      terminal_level
);
  // ************************************************************
  // Sensor wiring
  // ************************************************************
  // Levels settle on the clock so the block never sees a mid-cycle edge
  always_ff @(posedge aclk) begin
    terminal_level <= sensor_drive;
  end
endmodule : iois_field_model

// [testbench/iois_top_test.sv]
`timescale 1ns/1ps
`include "iois_params.svh"
module iois_top_test
  import iois_pkg::*;
;
  // ************************************************************
  // Signals and model state
  // ************************************************************
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  iois_lines_t sensor_drive, terminal_level, input_line;
  iois_outs_t  internal_out, output_line;
  int          bad_count, checks, i, j;
  bit [31:0]   m_mask, m_sel, m_lvl, m_sto, s_mask, s_sto;
  bit          m_refused;
  logic [7:0]  addrs [7] = '{`IOIS_OFF_MASK, `IOIS_OFF_SEL, `IOIS_OFF_LVL, `IOIS_OFF_STO,
                             `IOIS_OFF_STAT, `IOIS_OFF_LINES, `IOIS_OFF_CTRL};

  iois_top iois_top_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .terminal_level(terminal_level), .internal_out(internal_out), .input_line(input_line),
    .output_line(output_line)
  );

  iois_field_model iois_field_model_i (
    .aclk(aclk), .sensor_drive(sensor_drive), .terminal_level(terminal_level)
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  function automatic logic [1:0] exp_resp(input logic [7:0] a);
    return (a <= `IOIS_OFF_CTRL && a[1:0] == 2'h0) ? `IOIS_RESP_OKAY : `IOIS_RESP_SLVERR;
  endfunction : exp_resp

  function automatic logic [31:0] exp_in();
    logic [9:0] sim;
    sim = m_sel[9:0] & ~m_sto[9:0];
    return {22'h0, (sim & m_lvl[9:0]) | (~sim & sensor_drive)};
  endfunction : exp_in

  // ************************************************************
  // Bus master, bready and rready stay high throughout
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) begin
      chk("write response", 32'h0, 32'h1);
      conclude();
    end
    chk("awready wready held", {30'h0, awready, wready}, 32'h0);
    r = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr  <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) begin
      chk("read response", 32'h0, 32'h1);
      conclude();
    end
    chk("arready held", {31'h0, arready}, 32'h0);
    d = rdata;
    r = rresp;
  endtask : rd

  // Byte lanes not strobed keep their old value
  function automatic bit [31:0] mrg(input bit [31:0] o, input bit [31:0] d);
    bit [31:0] v;
    v = o;
    for (int b = 0; b < 4; b++) begin
      if (wstrb[b]) v[8*b +: 8] = d[8*b +: 8];
    end
    return v;
  endfunction : mrg

  // Write through the bus and update the reference image
  task automatic mw(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    bit [31:0]  om;
    bit [31:0]  os;
    bit [31:0]  nv;
    wr(a, d, r);
    chk($sformatf("bresp at %h", a), {30'h0, r}, {30'h0, exp_resp(a)});
    om = m_mask;
    os = m_sto;
    case (a)
      `IOIS_OFF_MASK: m_mask = mrg(m_mask, d);
      `IOIS_OFF_LVL: m_lvl = mrg(m_lvl, d);
      `IOIS_OFF_SEL: begin
        nv = mrg(m_sel, d);
        m_refused |= (nv[9:0] & m_sto[9:0]) != 10'h0;
        m_sel = nv & ~{22'h0, m_sto[9:0]};
      end
      `IOIS_OFF_STO: begin
        m_sto = mrg(m_sto, d);
        m_sel[9:0] &= ~m_sto[9:0];
      end
      `IOIS_OFF_STAT: begin
        if (wstrb[0] && d[0]) m_refused = 1'b0;
      end
      `IOIS_OFF_CTRL: begin
        // Backup image never holds select or level
        if (wstrb[0] && d[1]) begin
          m_mask = s_mask;
          m_sto = s_sto;
          m_sel[9:0] &= ~s_sto[9:0];
        end
        if (wstrb[0] && d[0]) begin
          s_mask = om;
          s_sto = os;
        end
      end
      default: ;
    endcase
  endtask : mw

  task automatic mr(input logic [7:0] a);
    logic [31:0] d;
    logic [1:0]  r;
    logic [31:0] e;
    rd(a, d, r);
    case (a)
      `IOIS_OFF_MASK: e = m_mask;
      `IOIS_OFF_SEL: e = m_sel;
      `IOIS_OFF_LVL: e = m_lvl;
      `IOIS_OFF_STO: e = m_sto;
      `IOIS_OFF_STAT: e = {30'h0, m_sel[9:0] != 10'h0, m_refused};
      `IOIS_OFF_LINES: e = exp_in();
      default: e = 32'h0;
    endcase
    chk($sformatf("rdata at %h", a), d, e);
    chk($sformatf("rresp at %h", a), {30'h0, r}, {30'h0, exp_resp(a)});
  endtask : mr

  task automatic ml();
    repeat (3) @(posedge aclk);
    chk("output_line", {30'h0, output_line}, {30'h0, internal_out ^ m_mask[1:0]});
    chk("input_line", {22'h0, input_line}, exp_in());
  endtask : ml

  task automatic stir();
    sensor_drive <= 10'($urandom());
    internal_out <= 2'($urandom());
    ml();
  endtask : stir

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {bready, rready, wstrb} = 6'h3F;
    sensor_drive = 10'h000;
    internal_out = 2'h0;
    void'($urandom(24));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 7; i++) mr(addrs[i]);
    mr(8'h1C);
    mr(8'h02);
    mw(8'h20, 32'h1234_5678);
    mw(`IOIS_OFF_LINES, 32'h0000_03FF);
    mr(`IOIS_OFF_MASK);
    $display("test reset_and_map done");
    for (i = 0; i < 4; i++) begin
      internal_out <= 2'(i + 1);
      mw(`IOIS_OFF_MASK, ($urandom() & 32'hFFFF_FFFC) | 32'(i));
      #1;
      chk("output_line at once", {30'h0, output_line}, {30'h0, internal_out ^ m_mask[1:0]});
      @(posedge aclk);
      for (j = 0; j < 4; j++) begin
        internal_out <= 2'(j);
        ml();
      end
      mr(`IOIS_OFF_MASK);
    end
    $display("test polarity done");
    for (i = 0; i < 12; i++) begin
      mw(`IOIS_OFF_SEL, $urandom());
      mw(`IOIS_OFF_LVL, $urandom());
      stir();
      mr(`IOIS_OFF_LINES);
      mr(`IOIS_OFF_SEL);
      mr(`IOIS_OFF_STAT);
    end
    mw(`IOIS_OFF_SEL, 32'h0000_03FF);
    stir();
    mw(`IOIS_OFF_SEL, 32'h0000_0000);
    stir();
    // Partial byte strobes merge into the old value
    wstrb <= 4'h2;
    mw(`IOIS_OFF_SEL, $urandom());
    wstrb <= 4'h1;
    mw(`IOIS_OFF_MASK, $urandom());
    wstrb <= 4'hE;
    mw(`IOIS_OFF_CTRL, 32'h0000_0003);
    wstrb <= 4'hF;
    mr(`IOIS_OFF_SEL);
    mr(`IOIS_OFF_MASK);
    stir();
    $display("test simulation done");
    mw(`IOIS_OFF_MASK, 32'hA5A5_0002);
    mw(`IOIS_OFF_CTRL, 32'h0000_0001);
    mw(`IOIS_OFF_MASK, 32'h0000_0001);
    mw(`IOIS_OFF_SEL, $urandom());
    mw(`IOIS_OFF_LVL, $urandom());
    mw(`IOIS_OFF_CTRL, 32'h0000_0002);
    for (i = 0; i < 7; i++) mr(addrs[i]);
    stir();
    // Save and restore together: the old image comes back, the current one is kept
    mw(`IOIS_OFF_MASK, 32'h0000_0001);
    mw(`IOIS_OFF_CTRL, 32'h0000_0003);
    for (i = 0; i < 7; i++) mr(addrs[i]);
    stir();
    $display("test backup done");
    mw(`IOIS_OFF_STO, $urandom() | 32'h0000_0021);
    mw(`IOIS_OFF_SEL, 32'hFFFF_FFFF);
    mr(`IOIS_OFF_SEL);
    mr(`IOIS_OFF_STAT);
    stir();
    mr(`IOIS_OFF_LINES);
    mw(`IOIS_OFF_STAT, 32'h0000_0001);
    mr(`IOIS_OFF_STAT);
    mw(`IOIS_OFF_STO, 32'h0000_0000);
    mw(`IOIS_OFF_SEL, 32'hFFFF_FFFF);
    mw(`IOIS_OFF_STO, 32'h0000_0200);
    mr(`IOIS_OFF_SEL);
    mr(`IOIS_OFF_STAT);
    stir();
    $display("test refusal done");
    conclude();
  end
endmodule : iois_top_test
